// file: verilog/sfrb_pkg.sv
package sfrb_pkg;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_KBCTL = 8'h94;
  localparam logic [7:0] ADDR_CLOCK_DIVIDE_CONTROL = 8'h95;
  localparam logic [7:0] ADDR_AUXF = 8'hA2;
  localparam logic [7:0] ADDR_IEN1ST = 8'hA8;
  localparam logic [7:0] ADDR_COMPARATOR_ONE_CONTROL = 8'hAC;
  localparam logic [7:0] ADDR_PR1U = 8'hB7;
  localparam logic [7:0] ADDR_PR1L = 8'hB8;
  localparam logic [7:0] ADDR_ACCUM = 8'hE0;
  localparam logic [7:0] ADDR_FLCTL = 8'hE4;
  localparam logic [7:0] ADDR_FLDATA = 8'hE5;
  localparam logic [7:0] ADDR_FLADL = 8'hE6;
  localparam logic [7:0] ADDR_FLADH = 8'hE7;
  localparam logic [7:0] ADDR_IEN2ND = 8'hE8;
  localparam logic [7:0] ADDR_MULOP = 8'hF0;
  localparam logic [7:0] ADDR_PR2U = 8'hF7;
  localparam logic [7:0] ADDR_PR2L = 8'hF8;
  // Interrupt status / mask of this block
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hC8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC9;
  // Port output-type config: one 2-bit code per pin, 4 pins per register
  localparam logic [7:0] ADDR_PCFG0_LO = 8'hC4;
  localparam logic [7:0] ADDR_PCFG0_HI = 8'hC5;
  localparam logic [7:0] ADDR_PCFG1_LO = 8'hC6;
  localparam logic [7:0] ADDR_PCFG1_HI = 8'hC7;

  localparam logic [7:0] RST_FLCTL = 8'h70;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MASK_PR1U = 8'h6A;
  localparam logic [7:0] MASK_PR2U = 8'h06;
  localparam logic [7:0] MASK_COMPARATOR_ONE_CONTROL = 8'h2B;
  localparam logic [7:0] MASK_COMPARATOR_ONE_CONTROL_SW = 8'h29;
  localparam logic [7:0] MASK_AUXF = 8'hDD;
  localparam logic [7:0] MASK_AUXF_ZERO = 8'h04;
  localparam int FL_BUSY_BIT = 7;
  localparam int CMP_OUT_BIT = 1;
  localparam int CMP_CHG_BIT = 0;
  localparam int P1_RSTPIN_BIT = 5;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Port pin output modes
  typedef enum logic [1:0] {
    SFRB_PM_QUASI = 2'h0,
    SFRB_PM_PUSHPULL = 2'h1,
    SFRB_PM_INPUT = 2'h2,
    SFRB_PM_OPENDRAIN = 2'h3
  } sfrb_pmode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfrb_req_s;
endpackage

// file: verilog/sfrb_top.sv
// Functional notes
// - During reset every port pin is input only with pull-up off.
// - Each port pin keeps its own output-type configuration; port 1 pin 5 is held input only whatever is written.
// - Reset pin acts as reset at power-on, otherwise only if configured.
// - Active reset pin low resets ports, peripherals, fetch restarts at 0.
// - Reset pin sampled during power-on to choose in-system programming.
// - Reserved bits written zero; reads may return anything.
// - Constant-zero bits always read zero.
// - Constant-one bits always read one; flash control bits 6:4 are such bits.
// - Flash control read gives busy, abort, error, security, interrupted; resets 70.
// - Flash control write is an eight-bit flash command.
// - Clock divide register is eight-bit read/write, reset 00.
// - Priority upper register one holds four source bits, reset 00.
// - Priority upper register two holds comparator and keypad bits.
// - Comparator one control: enable, neg select, output, change flag.
// - Bit-addressable registers accept single-bit writes at bit addresses.
`timescale 1ns/1ns
module sfrb_top
  import sfrb_pkg::*;
#(
  parameter int PORT_PINS = 8
)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic por_active_i,
  input wire logic user_config_byte_one_rst_en_i,
  input wire logic port1_bit5_input_pin_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_bit_i,
  input wire logic [7:0] sfr_bit_addr_i,
  input wire logic flash_busy_i,
  input wire logic [3:0] flash_flags_i,
  input wire logic comparator_one_output_i,
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] flash_command_code_o,
  output logic flash_command_valid_o,
  output logic [7:0] clock_divide_o,
  output logic [7:0] prio_upper_o,
  output logic [7:0] prio_lower_o,
  output logic [7:0] comparator_one_control_o,
  output logic [2*PORT_PINS-1:0] port0_mode_o,
  output logic [2*PORT_PINS-1:0] port1_mode_o,
  output logic in_system_programming_mode_o,
  output logic sys_reset_o,
  output logic [15:0] fetch_addr_o,
  output logic irq_o
);
  // Port mode registers are laid out for exactly eight pins per port
  if (PORT_PINS != 8)
  begin
    $error("PORT_PINS must be 8");
  end

  sfrb_req_s req;
  assign req = '{addr: sfr_addr_i, wdata: sfr_wdata_i, wr: sfr_wr_i, rd: sfr_rd_i};

  logic pin_rst_active;
  assign pin_rst_active = (por_active_i | user_config_byte_one_rst_en_i)
                          & ~port1_bit5_input_pin_i;
  logic srst;
  assign srst = pin_rst_active;
  assign sys_reset_o = pin_rst_active | ~arst_n_i;

  logic [7:0] dpl_reg, dph_reg, kbctl_reg, clock_divide_control_reg, auxf_reg, interrupt_enable_second_reg;
  logic [7:0] comparator_one_control_reg, pr1u_reg, pr1l_reg, acc_reg, fldata_reg, fladl_reg;
  logic [7:0] fladh_reg, ien2_reg, mulop_reg, pr2u_reg, pr2l_reg;
  logic [7:0] flcmd_reg, irq_stat_reg, irq_mask_reg, rdata_reg;
  logic flcmd_vld_reg, isp_reg, por_seen_reg, cmp_out_reg;
  logic [7:0] pcfg0_lo_reg, pcfg0_hi_reg, pcfg1_lo_reg, pcfg1_hi_reg;
  logic [15:0] fetch_reg;

  // bit-address decode to byte and bit
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    bit_byte = {ba[7:3], 3'h0};
  endfunction
  function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic sel_bit,
                                          input logic [2:0] idx, input logic v,
                                          input logic [7:0] full);
    logic [7:0] r;
    r = old;
    if (sel_bit)
      r[idx] = v;
    else
      r = full;
    wr_merge = r;
  endfunction

  wire bit_addressable = (bit_byte(sfr_bit_addr_i) == ADDR_ACCUM)
                       | (bit_byte(sfr_bit_addr_i) == ADDR_IEN2ND)
                       | (bit_byte(sfr_bit_addr_i) == ADDR_PR1L);
  wire bit_wr = sfr_wr_i & sfr_bit_i & bit_addressable;
  wire byte_wr = sfr_wr_i & ~sfr_bit_i;
  wire [7:0] wr_addr = sfr_bit_i ? bit_byte(sfr_bit_addr_i) : req.addr;
  wire [2:0] bit_idx = sfr_bit_addr_i[2:0];
  wire any_wr = byte_wr | bit_wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire cmp_change = comparator_one_output_i ^ cmp_out_reg;
  wire flash_cmd_ev = byte_wr & hit(wr_addr, ADDR_FLCTL);
  wire [7:0] irq_events = {6'h00, flash_cmd_ev, cmp_change & comparator_one_control_reg[5]};

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dpl_reg <= RST_ZERO;
      dph_reg <= RST_ZERO;
      kbctl_reg <= RST_ZERO;
      clock_divide_control_reg <= RST_ZERO;
      auxf_reg <= RST_ZERO;
      interrupt_enable_second_reg <= RST_ZERO;
      comparator_one_control_reg <= RST_ZERO;
      pr1u_reg <= RST_ZERO;
      pr1l_reg <= RST_ZERO;
      acc_reg <= RST_ZERO;
      fldata_reg <= RST_ZERO;
      fladl_reg <= RST_ZERO;
      fladh_reg <= RST_ZERO;
      ien2_reg <= RST_ZERO;
      mulop_reg <= RST_ZERO;
      pr2u_reg <= RST_ZERO;
      pr2l_reg <= RST_ZERO;
      flcmd_reg <= RST_ZERO;
      flcmd_vld_reg <= 1'b0;
      cmp_out_reg <= 1'b0;
      irq_stat_reg <= RST_ZERO;
      irq_mask_reg <= RST_ZERO;
      // all pins input only at reset
      pcfg0_lo_reg <= {4{SFRB_PM_INPUT}};
      pcfg0_hi_reg <= {4{SFRB_PM_INPUT}};
      pcfg1_lo_reg <= {4{SFRB_PM_INPUT}};
      pcfg1_hi_reg <= {4{SFRB_PM_INPUT}};
      fetch_reg <= RESET_VECTOR;
    end
    else if (srst)
    begin
      // pin reset returns defaults, fetch at 0
      dpl_reg <= RST_ZERO;
      dph_reg <= RST_ZERO;
      kbctl_reg <= RST_ZERO;
      clock_divide_control_reg <= RST_ZERO;
      auxf_reg <= RST_ZERO;
      interrupt_enable_second_reg <= RST_ZERO;
      comparator_one_control_reg <= RST_ZERO;
      pr1u_reg <= RST_ZERO;
      pr1l_reg <= RST_ZERO;
      acc_reg <= RST_ZERO;
      fldata_reg <= RST_ZERO;
      fladl_reg <= RST_ZERO;
      fladh_reg <= RST_ZERO;
      ien2_reg <= RST_ZERO;
      mulop_reg <= RST_ZERO;
      pr2u_reg <= RST_ZERO;
      pr2l_reg <= RST_ZERO;
      flcmd_reg <= RST_ZERO;
      flcmd_vld_reg <= 1'b0;
      cmp_out_reg <= 1'b0;
      irq_stat_reg <= RST_ZERO;
      irq_mask_reg <= RST_ZERO;
      pcfg0_lo_reg <= {4{SFRB_PM_INPUT}};
      pcfg0_hi_reg <= {4{SFRB_PM_INPUT}};
      pcfg1_lo_reg <= {4{SFRB_PM_INPUT}};
      pcfg1_hi_reg <= {4{SFRB_PM_INPUT}};
      fetch_reg <= RESET_VECTOR;
    end
    else
    begin
      cmp_out_reg <= comparator_one_output_i;
      flcmd_vld_reg <= flash_cmd_ev;
      if (byte_wr)
      begin
        if (hit(wr_addr, ADDR_DPL)) dpl_reg <= req.wdata;
        if (hit(wr_addr, ADDR_DPH)) dph_reg <= req.wdata;
        if (hit(wr_addr, ADDR_KBCTL)) kbctl_reg <= req.wdata;
        if (hit(wr_addr, ADDR_CLOCK_DIVIDE_CONTROL)) clock_divide_control_reg <= req.wdata;
        if (hit(wr_addr, ADDR_AUXF)) auxf_reg <= req.wdata & MASK_AUXF;
        if (hit(wr_addr, ADDR_IEN1ST)) interrupt_enable_second_reg <= req.wdata;
        // upper priority bits one, reserved dropped
        if (hit(wr_addr, ADDR_PR1U)) pr1u_reg <= req.wdata & MASK_PR1U;
        if (hit(wr_addr, ADDR_PR2U)) pr2u_reg <= req.wdata & MASK_PR2U;
        if (hit(wr_addr, ADDR_FLCTL)) flcmd_reg <= req.wdata;
        if (hit(wr_addr, ADDR_FLDATA)) fldata_reg <= req.wdata;
        if (hit(wr_addr, ADDR_FLADL)) fladl_reg <= req.wdata;
        if (hit(wr_addr, ADDR_FLADH)) fladh_reg <= req.wdata;
        if (hit(wr_addr, ADDR_MULOP)) mulop_reg <= req.wdata;
        if (hit(wr_addr, ADDR_PR2L)) pr2l_reg <= req.wdata;
        if (hit(wr_addr, ADDR_IRQ_MASK)) irq_mask_reg <= req.wdata;
        // per-pin config, bit 5 of port 1 forced input
        if (hit(wr_addr, ADDR_PCFG0_LO)) pcfg0_lo_reg <= req.wdata;
        if (hit(wr_addr, ADDR_PCFG0_HI)) pcfg0_hi_reg <= req.wdata;
        if (hit(wr_addr, ADDR_PCFG1_LO)) pcfg1_lo_reg <= req.wdata;
        if (hit(wr_addr, ADDR_PCFG1_HI))
          pcfg1_hi_reg <= {req.wdata[7:4], SFRB_PM_INPUT, req.wdata[1:0]};
      end
      // bit or byte writes to bit-addressable registers
      if (any_wr & hit(wr_addr, ADDR_ACCUM))
        acc_reg <= wr_merge(acc_reg, sfr_bit_i, bit_idx, sfr_wdata_i[0], req.wdata);
      if (any_wr & hit(wr_addr, ADDR_IEN2ND))
        ien2_reg <= wr_merge(ien2_reg, sfr_bit_i, bit_idx, sfr_wdata_i[0], req.wdata);
      if (any_wr & hit(wr_addr, ADDR_PR1L))
        pr1l_reg <= wr_merge(pr1l_reg, sfr_bit_i, bit_idx, sfr_wdata_i[0], req.wdata);
      // software bits, flag set wins over clear
      if (byte_wr & hit(wr_addr, ADDR_COMPARATOR_ONE_CONTROL))
        comparator_one_control_reg <= (req.wdata & MASK_COMPARATOR_ONE_CONTROL_SW) | {7'h00, cmp_change & req.wdata[5]};
      else if (cmp_change & comparator_one_control_reg[5])
        comparator_one_control_reg[CMP_CHG_BIT] <= 1'b1;
      // Sticky status; set wins over write-one-to-clear
      if (byte_wr & hit(wr_addr, ADDR_IRQ_STAT))
        irq_stat_reg <= (irq_stat_reg & ~req.wdata) | irq_events;
      else
        irq_stat_reg <= irq_stat_reg | irq_events;
    end
  end

  // sample pin while power-on is in progress
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      isp_reg <= 1'b0;
      por_seen_reg <= 1'b0;
    end
    else if (por_active_i)
    begin
      isp_reg <= ~port1_bit5_input_pin_i;
      por_seen_reg <= 1'b1;
    end
  end

  wire [7:0] comparator_one_control_view = {comparator_one_control_reg[7:2], cmp_out_reg, comparator_one_control_reg[CMP_CHG_BIT]} & MASK_COMPARATOR_ONE_CONTROL;
  wire [7:0] flctl_view = {flash_busy_i, RST_FLCTL[6:4], flash_flags_i};

  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (req.addr)
      ADDR_DPL: rd_mux = dpl_reg;
      ADDR_DPH: rd_mux = dph_reg;
      ADDR_KBCTL: rd_mux = kbctl_reg;
      ADDR_CLOCK_DIVIDE_CONTROL: rd_mux = clock_divide_control_reg;
      ADDR_AUXF: rd_mux = auxf_reg & ~MASK_AUXF_ZERO;
      ADDR_IEN1ST: rd_mux = interrupt_enable_second_reg;
      ADDR_COMPARATOR_ONE_CONTROL: rd_mux = comparator_one_control_view;
      ADDR_PR1U: rd_mux = pr1u_reg;
      ADDR_PR1L: rd_mux = pr1l_reg;
      ADDR_ACCUM: rd_mux = acc_reg;
      ADDR_FLCTL: rd_mux = flctl_view;
      ADDR_FLDATA: rd_mux = fldata_reg;
      ADDR_FLADL: rd_mux = fladl_reg;
      ADDR_FLADH: rd_mux = fladh_reg;
      ADDR_IEN2ND: rd_mux = ien2_reg;
      ADDR_MULOP: rd_mux = mulop_reg;
      ADDR_PR2U: rd_mux = pr2u_reg;
      ADDR_PR2L: rd_mux = pr2l_reg;
      ADDR_IRQ_STAT: rd_mux = irq_stat_reg;
      ADDR_IRQ_MASK: rd_mux = irq_mask_reg;
      ADDR_PCFG0_LO: rd_mux = pcfg0_lo_reg;
      ADDR_PCFG0_HI: rd_mux = pcfg0_hi_reg;
      ADDR_PCFG1_LO: rd_mux = pcfg1_lo_reg;
      ADDR_PCFG1_HI: rd_mux = pcfg1_hi_reg;
      default: rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_reg <= RST_ZERO;
    else if (req.rd)
      rdata_reg <= rd_mux;
  end

  assign sfr_rdata_o = rdata_reg;
  assign flash_command_code_o = flcmd_reg;
  assign flash_command_valid_o = flcmd_vld_reg;
  assign clock_divide_o = clock_divide_control_reg;
  assign prio_upper_o = pr1u_reg;
  assign prio_lower_o = pr1l_reg;
  assign comparator_one_control_o = comparator_one_control_view;
  assign port0_mode_o = {pcfg0_hi_reg, pcfg0_lo_reg};
  assign port1_mode_o = {pcfg1_hi_reg, pcfg1_lo_reg};
  assign in_system_programming_mode_o = isp_reg & por_seen_reg;
  assign fetch_addr_o = fetch_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule

// file: tb/sfrb_core_model.sv
`timescale 1ns/1ns
module sfrb_core_model
  import sfrb_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output sfrb_req_s req_o,
  output logic bit_o,
  output logic [7:0] bit_addr_o
);
  initial
  begin
    req_o = '0;
    bit_o = 1'b0;
    bit_addr_o = 8'h00;
  end
  // Callers also use undefined places and bits, such as byte C0 and bit address 95
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    bit_o <= b;
    bit_addr_o <= a;
    @(posedge clk_i);
    req_o.wr <= 1'b0;
    bit_o <= 1'b0;
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o.rd <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule

// file: tb/sfrb_assertions.sv
`timescale 1ns/1ns
module sfrb_assertions
  import sfrb_pkg::*;
#(
  parameter int PORT_PINS = 8
)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic por_active_i,
  input wire logic user_config_byte_one_rst_en_i,
  input wire logic port1_bit5_input_pin_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_bit_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] flash_command_code_o,
  input wire logic flash_command_valid_o,
  input wire logic [7:0] clock_divide_o,
  input wire logic [7:0] prio_upper_o,
  input wire logic [2*PORT_PINS-1:0] port0_mode_o,
  input wire logic [2*PORT_PINS-1:0] port1_mode_o,
  input wire logic in_system_programming_mode_o,
  input wire logic sys_reset_o,
  input wire logic [15:0] fetch_addr_o
);
  wire [2*PORT_PINS-1:0] all_in = {PORT_PINS{2'h2}};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  pin_reset_a:
    assert property (sys_reset_o == (!port1_bit5_input_pin_i
      && (por_active_i || user_config_byte_one_rst_en_i))) else $error("reset pin decode");
  port_default_a:
    assert property (sys_reset_o |=> port0_mode_o == all_in && port1_mode_o == all_in)
      else $error("ports not input after reset");
  fetch_zero_a:
    assert property (sys_reset_o |=> fetch_addr_o == RESET_VECTOR) else $error("fetch not 0");
  pin5_input_a:
    assert property (port1_mode_o[2*P1_RSTPIN_BIT+:2] == 2'h2) else $error("pin 5 driven");
  isp_entry_a:
    assert property (por_active_i && !port1_bit5_input_pin_i |=> in_system_programming_mode_o)
      else $error("programming mode missed");
  div_read_a:
    assert property (sfr_rd_i && sfr_addr_i == ADDR_CLOCK_DIVIDE_CONTROL && !sys_reset_o |=>
      sfr_rdata_o == $past(clock_divide_o)) else $error("divider read wrong");
  flash_cmd_a:
    assert property (sfr_wr_i && !sfr_bit_i && sfr_addr_i == ADDR_FLCTL && !sys_reset_o |=>
      flash_command_valid_o && flash_command_code_o == $past(sfr_wdata_i))
      else $error("flash command lost");
  prio_rsv_a:
    assert property ((prio_upper_o & ~MASK_PR1U) == 8'h00) else $error("reserved bit set");
endmodule
bind sfrb_top sfrb_assertions #(.PORT_PINS(PORT_PINS)) u_chk (.*);

// file: tb/tb_sfr_map_and_port_reset_slice.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module tb_sfr_map_and_port_reset_slice
  import sfrb_pkg::*;
;
  logic clk, arst_n, por, cfg, pin, busy, cmp, bsel, fv, in_system_programming_mode, srst, irq;
  logic [3:0] flags;
  logic [7:0] d, ba, rdata, fc, cdiv, pup, plo, cctl;
  logic [15:0] p0m, p1m, fa;
  sfrb_req_s req;
  int bad_count, tests_run;
  localparam logic [7:0] A [10] = '{ADDR_DPL, ADDR_CLOCK_DIVIDE_CONTROL, ADDR_AUXF, ADDR_COMPARATOR_ONE_CONTROL, ADDR_PR1U,
    ADDR_PR2U, ADDR_ACCUM, ADDR_MULOP, ADDR_FLCTL, 8'hC0};
  localparam logic [7:0] W [10] = '{8'hFF, 8'hFF, 8'h00, MASK_COMPARATOR_ONE_CONTROL_SW, MASK_PR1U,
    MASK_PR2U, 8'hFF, 8'hFF, 8'h00, 8'h00};
  sfrb_top #(.PORT_PINS(8)) u_dut (.sys_clk_i(clk), .arst_n_i(arst_n), .por_active_i(por),
    .user_config_byte_one_rst_en_i(cfg), .port1_bit5_input_pin_i(pin),
    .sfr_addr_i(req.addr), .sfr_wdata_i(req.wdata), .sfr_wr_i(req.wr), .sfr_rd_i(req.rd),
    .sfr_bit_i(bsel), .sfr_bit_addr_i(ba), .flash_busy_i(busy), .flash_flags_i(flags),
    .comparator_one_output_i(cmp), .sfr_rdata_o(rdata), .flash_command_code_o(fc),
    .flash_command_valid_o(fv), .clock_divide_o(cdiv), .prio_upper_o(pup),
    .prio_lower_o(plo), .comparator_one_control_o(cctl), .port0_mode_o(p0m),
    .port1_mode_o(p1m), .in_system_programming_mode_o(in_system_programming_mode), .sys_reset_o(srst),
    .fetch_addr_o(fa), .irq_o(irq));
  sfrb_core_model u_core (.clk_i(clk), .rdata_i(rdata), .req_o(req), .bit_o(bsel),
    .bit_addr_o(ba));
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_core.rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_core.wr(a, v, 1'b0);
    #1;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run is a little over a hundred cycles
  initial
  begin
    #100000;
    bad_count++;
    test_done;
  end
  initial
  begin
    {arst_n, por, cfg, pin, busy, cmp} = 6'b010100;
    flags = 4'h0;
    repeat (16) @(posedge clk);
    `CHK("port1 in reset", 16'hAAAA, p1m)
    arst_n <= 1'b1;
    @(posedge clk) por <= 1'b0;
    for (int i = 0; i < 10; i++)
      rchk(A[i], A[i] == ADDR_FLCTL ? RST_FLCTL : RST_ZERO);
    for (int i = 0; i < 10; i++)
      if (W[i] != 8'h00)
        wr(A[i], W[i]);
    for (int i = 0; i < 10; i++)
      rchk(A[i], W[i] != 8'h00 ? W[i] : (A[i] == ADDR_FLCTL ? RST_FLCTL : RST_ZERO));
    `CHK("cmp ctl", MASK_COMPARATOR_ONE_CONTROL_SW, cctl)
    u_core.wr(8'hE3, 8'h00, 1'b1);
    u_core.wr(8'hB9, 8'h01, 1'b1);
    u_core.wr(8'hE9, 8'h01, 1'b1);
    u_core.wr(8'h95, 8'h00, 1'b1);
    rchk(ADDR_ACCUM, 8'hF7);
    rchk(ADDR_IEN2ND, 8'h02);
    `CHK("prio lower", 8'h02, plo)
    `CHK("divider", 8'hFF, cdiv)
    wr(ADDR_FLCTL, 8'hA5);
    `CHK("flash pulse", 1'b1, fv)
    `CHK("flash cmd", 8'hA5, fc)
    @(posedge clk) {busy, flags} <= {1'b1, 4'h5};
    rchk(ADDR_FLCTL, 8'hF5);
    @(posedge clk) busy <= 1'b0;
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 8'h02);
    `CHK("irq set", 1'b1, irq)
    wr(ADDR_IRQ_STAT, 8'h02);
    `CHK("irq clear", 1'b0, irq)
    wr(ADDR_COMPARATOR_ONE_CONTROL, 8'h20);
    @(posedge clk) cmp <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(ADDR_COMPARATOR_ONE_CONTROL, 8'h23);
    rchk(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    `CHK("cmp irq", 1'b1, irq)
    wr(ADDR_PCFG1_HI, 8'h55);
    wr(ADDR_PCFG0_LO, 8'hFF);
    `CHK("port1 mode", 16'h59AA, p1m)
    `CHK("port0 mode", 16'hAAFF, p0m)
    @(posedge clk) pin <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("pin ignored", 1'b0, srst)
    @(posedge clk) cfg <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("pin reset", 1'b1, srst)
    `CHK("port0 back", 16'hAAAA, p0m)
    `CHK("fetch", RESET_VECTOR, fa)
    `CHK("irq reset", 1'b0, irq)
    @(posedge clk) {pin, cfg} <= 2'b10;
    rchk(ADDR_CLOCK_DIVIDE_CONTROL, RST_ZERO);
    `CHK("no isp", 1'b0, in_system_programming_mode)
    @(posedge clk) {por, pin} <= 2'b10;
    @(posedge clk) {por, pin} <= 2'b01;
    repeat (2) @(posedge clk);
    #1 `CHK("isp", 1'b1, in_system_programming_mode)
    test_done;
  end
endmodule
